// ===== rtl/flash_caps_pkg.sv
package flash_caps_pkg;

   // ******************************
   // Parameter dword field layout
   // ******************************
   localparam int ENTER_HI = 31;
   localparam int ENTER_LO = 24;
   localparam int EXIT_HI = 23;
   localparam int EXIT_LO = 14;
   localparam int RESET_HI = 13;
   localparam int RESET_LO = 8;
   localparam int RFU_BIT = 7;
   localparam int SR1_HI = 6;
   localparam int SR1_LO = 0;

   // ******************************
   // Field values
   // ******************************
   localparam logic [7:0] ENTER_NONE = 8'h80;
   localparam logic [9:0] EXIT_NONE = 10'h300;
   localparam logic [5:0] RESET_SEQ = 6'h10;
   localparam logic RFU_VAL = 1'b1;
   localparam logic [6:0] SR1_NV_WREN = 7'h68;

   // ******************************
   // Command bytes
   // ******************************
   localparam logic [7:0] CMD_RESET_EN = 8'h66;
   localparam logic [7:0] CMD_RESET = 8'h99;
   localparam logic [7:0] CMD_WRITE_EN = 8'h06;

   // ******************************
   // Shifter and synchroniser constants
   // ******************************
   localparam logic [3:0] CMD_BITS = 4'h8;
   localparam logic [3:0] LANES_SINGLE = 4'h1;
   localparam logic [3:0] LANES_DUAL = 4'h2;
   localparam logic [3:0] LANES_QUAD = 4'h4;
   localparam int SYNC_OUT = 1;
   localparam int SYNC_OLD = 2;
   localparam logic [2:0] SYNC_HIGH = 3'h7;

   // Bus width of the current operating mode
   typedef enum logic [1:0] {
      WIDTH_SINGLE = 2'h0,
      WIDTH_DUAL = 2'h1,
      WIDTH_QUAD = 2'h3
   } width_t;

   typedef enum logic [1:0] {
      ARM_IDLE = 2'h0,
      ARM_ENABLED = 2'h1
   } arm_t;

   // Decoded command strobe from the shifter
   typedef struct packed {
      logic valid;
      logic [7:0] code;
   } cmd_t;

   typedef struct packed {
      logic [7:0] shift;
      logic [3:0] count;
      logic first;
      cmd_t cmd;
      arm_t arm;
      logic soft_reset;
      logic write_en;
      logic [2:0] csn_sync;
      logic [2:0] sck_sync;
      logic [3:0] io_meta;
      logic [3:0] io_sync;
      logic [31:0] caps;
   } state_t;

endpackage : flash_caps_pkg

// ===== rtl/flash_reset_addressing_caps.sv
`timescale 1ns/100ps
// Behaviour
// R1: Enter field reports four-byte entry unsupported
// R2: Exit field reports no exit method
// R3: Reset enable 66h then reset 99h resets
// R4: Reset commands accepted on 1, 2, 4 lines
// R5: Low field declares status register 1 kind
// R6: Write enable 06h precedes nonvolatile write
// R7: Other command cancels pending reset enable
module flash_reset_addressing_caps (
   input wire logic clock,
   input wire logic srst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input flash_caps_pkg::width_t width_mode,
   output logic [31:0] caps_dword,
   output logic soft_reset,
   output logic write_enabled
);

   // ******************************
   // Parameter dword
   // ******************************
   // The word never changes at run time. It tells the host that this part
   // keeps three-byte addressing only, that a soft reset is the reset-enable
   // then reset pair, and that status register 1 is nonvolatile behind 06h.

   // Field values dropped into their slots, high field first
   function automatic logic [31:0] caps_word();
      logic [31:0] w;
      w = '0;
      // Four-byte entry is not offered
      w[flash_caps_pkg::ENTER_HI:flash_caps_pkg::ENTER_LO] = flash_caps_pkg::ENTER_NONE; // [R1]
      // No way out of four-byte mode is offered either
      w[flash_caps_pkg::EXIT_HI:flash_caps_pkg::EXIT_LO] = flash_caps_pkg::EXIT_NONE; // [R2]
      // Reset enable then reset, on any bus width
      w[flash_caps_pkg::RESET_HI:flash_caps_pkg::RESET_LO] = flash_caps_pkg::RESET_SEQ; // [R3]
      // Reserved bit reads as one
      w[flash_caps_pkg::RFU_BIT] = flash_caps_pkg::RFU_VAL;
      // Nonvolatile status register 1, written after 06h
      w[flash_caps_pkg::SR1_HI:flash_caps_pkg::SR1_LO] = flash_caps_pkg::SR1_NV_WREN; // [R5]
      return w;
   endfunction : caps_word

   // Constant word shown on caps_dword
   localparam logic [31:0] CAPS = caps_word();

   // ******************************
   // Decode helpers
   // ******************************
   // Small pure functions keep the next-state block readable and let the
   // same comparison serve the reset and the write-enable paths.

   // Push a pin sample into a three-stage chain
   function automatic logic [2:0] sync_push(input logic [2:0] chain, input logic pin);
      sync_push = {chain[1:0], pin};
   endfunction : sync_push

   // Bits shifted per serial clock edge for a bus width
   function automatic logic [3:0] bits_per_edge(input flash_caps_pkg::width_t w);
      case (w)
         flash_caps_pkg::WIDTH_DUAL: bits_per_edge = flash_caps_pkg::LANES_DUAL;
         flash_caps_pkg::WIDTH_QUAD: bits_per_edge = flash_caps_pkg::LANES_QUAD;
         // Unused width codes fall back to one line
         default: bits_per_edge = flash_caps_pkg::LANES_SINGLE;
      endcase
   endfunction : bits_per_edge

   // Next shifter contents, most significant bits first on every width
   function automatic logic [7:0] shift_in(input logic [7:0] shift,
      input logic [3:0] lines, input flash_caps_pkg::width_t w);
      logic [7:0] res;
      res = shift;
      // Low lines take the newest bits; unused lines are ignored
      case (w) // [R4]
         flash_caps_pkg::WIDTH_QUAD: res = {shift[3:0], lines[3:0]};
         flash_caps_pkg::WIDTH_DUAL: res = {shift[5:0], lines[1:0]};
         default: res = {shift[6:0], lines[0]};
      endcase
      return res;
   endfunction : shift_in

   // True when a completed command carries the given code
   function automatic logic code_is(input flash_caps_pkg::cmd_t c, input logic [7:0] code);
      code_is = c.valid && (c.code == code);
   endfunction : code_is

   // Arm state after one cycle; only completed commands move it
   function automatic flash_caps_pkg::arm_t arm_after(input flash_caps_pkg::arm_t arm,
      input flash_caps_pkg::cmd_t c);
      flash_caps_pkg::arm_t res;
      res = arm;
      // Gray order: idle and enabled differ in one bit
      if (c.valid) begin
         case (arm)
            flash_caps_pkg::ARM_IDLE: begin
               if (c.code == flash_caps_pkg::CMD_RESET_EN) begin // [R3]
                  res = flash_caps_pkg::ARM_ENABLED;
               end
            end
            flash_caps_pkg::ARM_ENABLED: begin
               // A repeated enable keeps the arm, any other code drops it
               if (c.code != flash_caps_pkg::CMD_RESET_EN) begin
                  res = flash_caps_pkg::ARM_IDLE; // [R7]
               end
            end
            default: res = flash_caps_pkg::ARM_IDLE;
         endcase
      end
      return res;
   endfunction : arm_after

   // ******************************
   // State and strobes
   // ******************************
   // Latency from the serial clock edge that completes a byte: two edges
   // through the synchroniser, a third that shifts the last bits and raises
   // the command strobe, and a fourth that moves the outputs. Each serial
   // clock phase must span at least one system clock or an edge is lost.
   flash_caps_pkg::state_t s_q;
   flash_caps_pkg::state_t s_d;
   // Helper strobes, all on the system clock
   logic sck_rise;
   logic frame_on;
   logic [3:0] count_next;
   logic [7:0] shift_next;
   logic reset_hit;
   logic wen_hit;

   // Edge and frame detect read past the first synchroniser stage only
   assign sck_rise = s_q.sck_sync[flash_caps_pkg::SYNC_OUT]
      & ~s_q.sck_sync[flash_caps_pkg::SYNC_OLD];
   assign frame_on = ~s_q.csn_sync[flash_caps_pkg::SYNC_OUT];

   // Shifter step for the current width
   assign shift_next = shift_in(s_q.shift, s_q.io_sync, width_mode); // [R4]
   // The count never passes seven plus four, so four bits suffice
   assign count_next = s_q.count + bits_per_edge(width_mode);

   // A reset needs an armed enable; a write enable needs only its code
   assign reset_hit = (s_q.arm == flash_caps_pkg::ARM_ENABLED)
      && code_is(s_q.cmd, flash_caps_pkg::CMD_RESET); // [R3] [R7]
   assign wen_hit = code_is(s_q.cmd, flash_caps_pkg::CMD_WRITE_EN); // [R6]

   // ******************************
   // Next state
   // ******************************
   // One pass computes every field; the register below copies it whole.
   // Bytes after the first in a frame are not shifted, so data phases of
   // longer commands can never be taken for a reset.
   always_comb begin
      s_d = s_q;
      // Two flops on every pin before any logic reads it
      s_d.csn_sync = sync_push(s_q.csn_sync, cs_n);
      s_d.sck_sync = sync_push(s_q.sck_sync, sck);
      s_d.io_meta = io_in;
      s_d.io_sync = s_q.io_meta;
      s_d.caps = CAPS;

      // Strobes stand for one cycle only
      s_d.cmd.valid = 1'b0;
      s_d.soft_reset = 1'b0;

      // Only the first byte of a frame is a command
      if (!frame_on) begin
         s_d.count = '0;
         s_d.first = 1'b1;
      end else if (sck_rise && s_q.first) begin
         s_d.shift = shift_next;
         s_d.count = count_next;
         if (count_next >= flash_caps_pkg::CMD_BITS) begin
            s_d.first = 1'b0;
            s_d.cmd.valid = 1'b1;
            s_d.cmd.code = shift_next;
         end
      end

      // Reset sequence tracking
      s_d.arm = arm_after(s_q.arm, s_q.cmd); // [R7]
      if (reset_hit) begin
         s_d.soft_reset = 1'b1; // [R3]
      end

      // Write enable set by 06h, dropped by a soft reset
      if (wen_hit) begin
         s_d.write_en = 1'b1; // [R6]
      end else if (reset_hit) begin
         s_d.write_en = 1'b0;
      end
   end

   // ******************************
   // State register
   // ******************************
   // Chip select idles high, so its chain resets high and no frame is seen
   always_ff @(posedge clock) begin
      if (srst) begin
         s_q <= '0;
         s_q.first <= 1'b1;
         s_q.csn_sync <= flash_caps_pkg::SYNC_HIGH;
         s_q.arm <= flash_caps_pkg::ARM_IDLE;
         s_q.caps <= CAPS;
      end else begin
         s_q <= s_d;
      end
   end

   // ******************************
   // Outputs
   // ******************************
   // Every output is a field of the state register,
   // so none of them passes through logic on its way out
   assign caps_dword = s_q.caps;
   assign soft_reset = s_q.soft_reset;
   assign write_enabled = s_q.write_en;

   // ******************************
   // Limitations
   // ******************************
   // Only the arm state, the write enable latch, the command shifter, the parameter dword and the synchronisers are
   // kept here; the array, the status register contents and the table read
   // command live elsewhere. A cut frame simply restarts the shifter, so a
   // partial byte is dropped without effect on the arm state.

endmodule : flash_reset_addressing_caps

// ===== tb/flash_caps_monitor.sv
`timescale 1ns/100ps
module flash_caps_monitor (
   input wire logic clock,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic [31:0] caps_dword,
   input wire logic soft_reset,
   input wire logic write_enabled
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // Table fields, reset pulse and write enable
   a_enter_field: assert property (caps_dword[31:24] == 8'h80)
      else $error("enter field wrong");
   a_exit_field: assert property (caps_dword[23:14] == 10'h300)
      else $error("exit field wrong");
   a_reset_field: assert property (caps_dword[13:8] == 6'h10)
      else $error("reset field wrong");
   a_sr1_field: assert property (caps_dword[6:0] == 7'h68)
      else $error("status field wrong");
   a_pulse_single: assert property (soft_reset |=> !soft_reset)
      else $error("reset pulse too long");
   a_reset_clears_wen: assert property (soft_reset |=> !write_enabled)
      else $error("write enable kept");
   a_idle_no_reset: assert property (cs_n [*8] |=> !soft_reset)
      else $error("reset while idle");
   a_idle_wen_hold: assert property (cs_n [*8] |=> $stable(write_enabled))
      else $error("write enable moved");
endmodule : flash_caps_monitor
bind flash_reset_addressing_caps flash_caps_monitor mon_u (.clock(clock), .srst(srst),
   .cs_n(cs_n), .caps_dword(caps_dword), .soft_reset(soft_reset),
   .write_enabled(write_enabled));

// ===== tb/flash_reset_addressing_caps_tb_top.sv
`timescale 1ns/100ps
module flash_reset_addressing_caps_tb_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic sck, cs_n, soft_reset, wen;
   logic [3:0] io;
   logic [31:0] caps;
   logic [1:0] ws[3] = '{2'h0, 2'h1, 2'h3};
   logic [7:0] r;
   flash_caps_pkg::width_t wm = flash_caps_pkg::WIDTH_SINGLE;
   int error_cnt = 0;
   int checks_done = 0;
   logic q[$];
   initial forever #5 clock = ~clock;
   spi_host_model host_u (.clock(clock), .sck(sck), .cs_n(cs_n), .io(io));
   flash_reset_addressing_caps dut_u (.clock(clock), .srst(srst), .sck(sck), .cs_n(cs_n),
      .io_in(io), .width_mode(wm), .caps_dword(caps), .soft_reset(soft_reset),
      .write_enabled(wen));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // Three frames; a pulse is noted before the last frame when expected
   task run(input logic [7:0] a, b, c, input logic p);
      host_u.send(a, wm);
      host_u.send(b, wm);
      if (p) q.push_back(1'b0);
      host_u.send(c, wm);
      repeat (12) @(posedge clock);
      #1 check(q.size(), 0);
      $display("test done");
   endtask : run
   // Each pulse takes the oldest note; write enable must then be clear
   always @(posedge clock) #2 if (soft_reset === 1'b1) begin
      if (q.size() == 0) check(1, 0);
      else check(wen, q.pop_front());
   end
   initial begin
      repeat (100000) @(posedge clock);
      check(1, 0);
      end_sim();
   end
   initial begin
      void'($urandom(85));
      repeat (12) @(posedge clock);
      #1 srst = 1'b0;
      repeat (4) @(posedge clock);
      #1 check(caps, 32'h80C010E8);
      foreach (ws[i]) begin
         wm = flash_caps_pkg::width_t'(ws[i]);
         run(8'h06, 8'h66, 8'h99, 1'b1);
         run(8'h66, 8'h66, 8'h99, 1'b1);
         run(8'h06, 8'h99, 8'h99, 1'b0);
         run(8'h66, 8'h06, 8'h99, 1'b0);
         check(wen, 1'b1);
      end
      repeat (6) begin
         wm = flash_caps_pkg::width_t'(ws[$urandom % 3]);
         r = $urandom % 2 ? 8'h66 : 8'($urandom % 8'h99); // Never 99h, which fires early
         run(8'h66, r, 8'h99, r == 8'h66);
      end
      end_sim();
   end
endmodule : flash_reset_addressing_caps_tb_top

// ===== tb/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
   input wire logic clock,
   output logic sck,
   output logic cs_n,
   output logic [3:0] io
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      io = 4'h5;
   end
   // One command byte, MSB first, in the bus width of the mode
   task send(input logic [7:0] b, input logic [1:0] w);
      int n;
      n = (w == 2'h3) ? 4 : (w == 2'h1) ? 2 : 1;
      // Chip select stays high a few cycles between frames
      repeat (4) @(posedge clock);
      #1 cs_n = 1'b0;
      for (int i = 0; i < 8; i += n) begin
         case (n)
            4: io = b[7:4];
            2: io = {2'h0, b[7:6]};
            default: io = {3'h0, b[7]};
         endcase
         b = b << n;
         repeat (3) @(posedge clock);
         #1 sck = 1'b1;
         repeat (3) @(posedge clock);
         #1 sck = 1'b0;
      end
      repeat (2) @(posedge clock);
      #1 cs_n = 1'b1;
      io = ~io;
   endtask : send
endmodule : spi_host_model
